// *** hdl/ars_pkg.sv ***
// constants and helpers for the conversion result slot register bank
package ars_pkg;

   // slot geometry
   localparam int unsigned ARS_MAX_SLOTS = 4;
   localparam int unsigned ARS_RES_W = 12;
   localparam int unsigned ARS_FIRST_SLOT = 2;

   // apb address space
   localparam int unsigned ARS_ADDR_W = 8;
   typedef logic [ARS_ADDR_W-1:0] ars_addr_t;
   localparam ars_addr_t ARS_OFF_SLOT_BASE = 8'h00;
   localparam int unsigned ARS_SLOT_STRIDE = 4;
   localparam ars_addr_t ARS_OFF_SLOT2 = 8'h00;
   localparam ars_addr_t ARS_OFF_SLOT3 = 8'h04;
   localparam ars_addr_t ARS_OFF_SLOT4 = 8'h08;
   localparam ars_addr_t ARS_OFF_SLOT5 = 8'h0c;
   localparam ars_addr_t ARS_OFF_INT_STATUS = 8'h10;
   localparam ars_addr_t ARS_OFF_INT_MASK = 8'h14;

   // slot word fields
   localparam int unsigned ARS_VAL_MSB = 15;
   localparam int unsigned ARS_VAL_LSB = 4;
   localparam int unsigned ARS_OVR_BIT = 1;
   localparam int unsigned ARS_STO_BIT = 0;

   // interrupt layout: stored events low nibble, overrun events high
   localparam int unsigned ARS_INT_W = 8;
   localparam int unsigned ARS_INT_STO_LSB = 0;
   localparam int unsigned ARS_INT_OVR_LSB = 4;

   // reset values
   localparam logic [31:0] ARS_SLOT_RESET = 32'h0000_0000;
   localparam logic [7:0] ARS_INT_STATUS_RESET = 8'h00;
   localparam logic [7:0] ARS_INT_MASK_RESET = 8'h00;
   localparam logic ARS_FLAG_RESET = 1'b0;

   typedef logic [31:0] ars_word_t;

   // build the software view of one slot
   function automatic ars_word_t ars_slot_word(input logic [11:0] v,
                                               input logic ovr,
                                               input logic sto);
      ars_word_t w;
      w = ARS_SLOT_RESET;
      w[ARS_VAL_MSB:ARS_VAL_LSB] = v;
      w[ARS_OVR_BIT] = ovr;
      w[ARS_STO_BIT] = sto;
      return w;
   endfunction

endpackage

// *** hdl/ars_slot.sv ***
// one conversion result slot with its stored and overrun flags
`timescale 1ns/1ps
module ars_slot #(
   parameter int unsigned RES_W = ars_pkg::ARS_RES_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic wr,
   input wire logic [RES_W-1:0] wr_value,
   input wire logic rd_clr,
   output logic [RES_W-1:0] value,
   output logic stored_flag,
   output logic overrun_flag,
   output logic store_evt,
   output logic overrun_evt
);
   import ars_pkg::*;

   assign store_evt = clk_en & wr;
   // a read in the same cycle consumes the old value, so no overrun
   assign overrun_evt = clk_en & wr & stored_flag & ~rd_clr;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         value <= '0;
      end else if (clk_en && wr) begin
         value <= wr_value;
      end
   end

   // set wins over a read clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stored_flag <= ARS_FLAG_RESET;
      end else if (clk_en) begin
         if (wr) begin
            stored_flag <= 1'b1;
         end else if (rd_clr) begin
            stored_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         overrun_flag <= ARS_FLAG_RESET;
      end else if (clk_en) begin
         if (overrun_evt) begin
            overrun_flag <= 1'b1;
         end else if (rd_clr) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_store_flag: assert property (
      clk_en && wr |=> stored_flag && value == $past(wr_value))
      else $error("slot did not store value or set stored flag");

   chk_overrun_set: assert property (
      clk_en && wr && stored_flag && !rd_clr |=> overrun_flag)
      else $error("overrun flag not set on unread overwrite");

   chk_no_false_ovr: assert property (
      clk_en && wr && !stored_flag && !overrun_flag |=> !overrun_flag)
      else $error("overrun flag set without an unread value");

   chk_read_clear: assert property (
      clk_en && rd_clr && !wr |=> !stored_flag && !overrun_flag)
      else $error("read did not clear slot flags");

   chk_slot_freeze: assert property (
      !clk_en |=> $stable(value) && $stable(stored_flag)
                  && $stable(overrun_flag))
      else $error("slot changed while clock enable low");

endmodule

// *** hdl/ars_top.sv ***
// apb register bank holding conversion result slots two to five
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

// Function
// - each slot keeps its latest 12-bit result read-only in bits 15..4.
// - a slot's overrun flag in bit 1 sets when a result lands unread.
// - a read covering the slot's low byte clears its overrun flag.
// - a slot's stored flag in bit 0 sets whenever a result is written.
// - that same low-byte read also clears the slot's stored flag.
module ars_top #(
   parameter int unsigned NUM_SLOTS = ars_pkg::ARS_MAX_SLOTS,
   parameter int unsigned RES_W = ars_pkg::ARS_RES_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire ars_pkg::ars_addr_t paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // sequencer result port
   input wire logic res_wr,
   input wire logic [1:0] res_slot,
   input wire logic [RES_W-1:0] res_value,
   // interrupt
   output logic irq
);
   import ars_pkg::*;

   if (NUM_SLOTS < 1 || NUM_SLOTS > ARS_MAX_SLOTS) begin : g_bad_slots
      $error("NUM_SLOTS must be 1 to 4");
   end
   if (RES_W < 1 || RES_W > ARS_RES_W) begin : g_bad_width
      $error("RES_W must be 1 to 12");
   end

   // decode of the slot addresses, one bit per slot
   function automatic logic [ARS_MAX_SLOTS-1:0] slot_hit(
      input ars_addr_t a
   );
      logic [ARS_MAX_SLOTS-1:0] h;
      h = '0;
      for (int k = 0; k < ARS_MAX_SLOTS; k++) begin
         h[k] = (a == ARS_OFF_SLOT_BASE
                      + ars_addr_t'(k * ARS_SLOT_STRIDE));
      end
      return h;
   endfunction

   logic [ARS_MAX_SLOTS-1:0] slot_present;
   logic [ARS_MAX_SLOTS-1:0] addr_hit;
   logic [ARS_MAX_SLOTS-1:0] res_hit;
   logic [ARS_MAX_SLOTS-1:0] rd_clr;
   logic [ARS_MAX_SLOTS-1:0] sto_flag;
   logic [ARS_MAX_SLOTS-1:0] ovr_flag;
   logic [ARS_MAX_SLOTS-1:0] sto_evt;
   logic [ARS_MAX_SLOTS-1:0] ovr_evt;
   ars_word_t slot_word [ARS_MAX_SLOTS];

   logic rd_setup;
   logic any_setup;
   logic wr_access;
   logic hit_status;
   logic hit_mask;
   logic [ARS_INT_W-1:0] int_status;
   logic [ARS_INT_W-1:0] int_mask;
   logic [ARS_INT_W-1:0] int_set;
   logic [ARS_INT_W-1:0] int_clr;
   logic [31:0] next_rdata;
   logic next_err;

   // bus phase decode; read side effects and data capture at setup
   assign rd_setup = clk_en & psel & ~penable & ~pwrite;
   assign any_setup = clk_en & psel & ~penable;
   assign wr_access = clk_en & psel & penable & pwrite;
   assign addr_hit = slot_hit(paddr) & slot_present;
   assign hit_status = (paddr == ARS_OFF_INT_STATUS);
   assign hit_mask = (paddr == ARS_OFF_INT_MASK);

   // every apb read is a full word, so it always covers the low byte
   assign rd_clr = addr_hit & {ARS_MAX_SLOTS{rd_setup}};

   // zero wait states; stalls only while the block is frozen
   assign pready = clk_en;

   genvar gi;
   for (gi = 0; gi < ARS_MAX_SLOTS; gi++) begin : g_slot
      if (gi < NUM_SLOTS) begin : g_on
         logic [RES_W-1:0] val;
         assign slot_present[gi] = 1'b1;
         assign res_hit[gi] = res_wr && (res_slot == 2'(gi));
         ars_slot #(
            .RES_W(RES_W)
         ) u_slot (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .clk_en(clk_en),
            .wr(res_hit[gi]),
            .wr_value(res_value),
            .rd_clr(rd_clr[gi]),
            .value(val),
            .stored_flag(sto_flag[gi]),
            .overrun_flag(ovr_flag[gi]),
            .store_evt(sto_evt[gi]),
            .overrun_evt(ovr_evt[gi])
         );
         // narrower results sit at the top of the value field
         assign slot_word[gi] = ars_slot_word(
            12'({val, {(ARS_RES_W - RES_W){1'b0}}}),
            ovr_flag[gi], sto_flag[gi]);
      end else begin : g_off
         assign slot_present[gi] = 1'b0;
         assign res_hit[gi] = 1'b0;
         assign sto_flag[gi] = 1'b0;
         assign ovr_flag[gi] = 1'b0;
         assign sto_evt[gi] = 1'b0;
         assign ovr_evt[gi] = 1'b0;
         assign slot_word[gi] = ARS_SLOT_RESET;
      end
   end

   // read mux and error decode
   always_comb begin
      next_rdata = '0;
      next_err = 1'b0;
      if (|addr_hit) begin
         for (int k = 0; k < ARS_MAX_SLOTS; k++) begin
            if (addr_hit[k] && !pwrite) begin
               next_rdata = slot_word[k];
            end
         end
      end else if (hit_status) begin
         if (!pwrite) begin
            next_rdata = {24'h00_0000, int_status};
         end
      end else if (hit_mask) begin
         if (!pwrite) begin
            next_rdata = {24'h00_0000, int_mask};
         end
      end else begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (any_setup) begin
         prdata <= next_rdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pslverr <= 1'b0;
      end else if (any_setup) begin
         pslverr <= next_err;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   assign int_set = {ovr_evt, sto_evt};
   assign int_clr = (wr_access && hit_status) ? pwdata[ARS_INT_W-1:0]
                                              : '0;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         int_status <= ARS_INT_STATUS_RESET;
      end else if (clk_en) begin
         int_status <= (int_status & ~int_clr) | int_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         int_mask <= ARS_INT_MASK_RESET;
      end else if (wr_access && hit_mask) begin
         int_mask <= pwdata[ARS_INT_W-1:0];
      end
   end

   assign irq = |(int_status & int_mask);

   default clocking dcb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_rd_setup(logic h);
      rd_setup && h;
   endsequence

   sequence s_rd_access;
      psel && penable && !pwrite && pready;
   endsequence

   sequence s_slot_read(logic h);
      s_rd_setup(h) ##1 s_rd_access;
   endsequence

   // result lands, a quiet cycle, then software reads that slot
   sequence s_fresh_read(logic w, logic h);
      clk_en && w ##1 !w ##1 s_slot_read(h);
   endsequence

   chk_rsvd_zero: assert property (
      s_rd_access and !pslverr
      |-> prdata[31:16] == 16'h0000
          && (!$past(|addr_hit) || prdata[3:2] == 2'b00))
      else $error("reserved read bits not zero");

   chk_irq_raise: assert property (
      clk_en && |(int_set & int_mask) && !(wr_access && hit_mask)
      |=> irq)
      else $error("unmasked event did not raise interrupt");

   chk_set_wins: assert property (
      clk_en && |int_set
      |=> (int_status & $past(int_set)) == $past(int_set))
      else $error("event lost against a status clear");

   chk_w1c_clear: assert property (
      wr_access && hit_status && int_set == '0
      |=> (int_status & $past(pwdata[ARS_INT_W-1:0])) == '0)
      else $error("write one did not clear status");

   chk_unmapped_err: assert property (
      any_setup && !(|addr_hit) && !hit_status && !hit_mask
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

   chk_bank_freeze: assert property (
      !clk_en |=> $stable(int_status) && $stable(int_mask)
                  && $stable(prdata) && $stable(pslverr))
      else $error("bank changed while clock enable low");

   chk_mask_write: assert property (
      wr_access && hit_mask
      |=> int_mask == $past(pwdata[ARS_INT_W-1:0]))
      else $error("mask write did not land");

   chk_status_read: assert property (
      s_rd_setup(hit_status) ##1 s_rd_access
      |-> prdata == {24'h00_0000, $past(int_status)})
      else $error("status read does not match status");

   chk_slot_no_err: assert property (
      any_setup && (|addr_hit) |=> !pslverr)
      else $error("slot access flagged as error");

   for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_chk
      chk_read_value: assert property (
         s_slot_read(addr_hit[gi])
         |-> prdata[ARS_VAL_MSB:ARS_VAL_LSB]
             == $past(slot_word[gi][ARS_VAL_MSB:ARS_VAL_LSB])
             && prdata[ARS_STO_BIT] == $past(sto_flag[gi]))
         else $error("read data does not match slot");

      chk_read_clears: assert property (
         s_rd_setup(addr_hit[gi]) and !res_hit[gi]
         |=> !ovr_flag[gi] && !sto_flag[gi])
         else $error("slot read left flags set");

      chk_ro_write: assert property (
         wr_access && addr_hit[gi] && !res_wr
         |=> $stable(slot_word[gi]))
         else $error("software write changed a slot");

      chk_read_ovr: assert property (
         s_slot_read(addr_hit[gi])
         |-> prdata[ARS_OVR_BIT] == $past(ovr_flag[gi]))
         else $error("read overrun bit does not match slot");

      chk_fresh_read: assert property (
         s_fresh_read(res_hit[gi], addr_hit[gi])
         |-> prdata[ARS_STO_BIT]
             && prdata[ARS_VAL_MSB -: RES_W] == $past(res_value, 3))
         else $error("fresh result not returned by read");

      chk_store_event: assert property (
         clk_en && res_hit[gi]
         |=> sto_flag[gi] && int_status[ARS_INT_STO_LSB + gi])
         else $error("stored flag or event missing");

      chk_overrun_event: assert property (
         clk_en && res_hit[gi] && sto_flag[gi] && !rd_clr[gi]
         |=> ovr_flag[gi] && int_status[ARS_INT_OVR_LSB + gi])
         else $error("overrun flag or event missing");

      chk_ovr_implies: assert property (
         ovr_flag[gi] |-> sto_flag[gi])
         else $error("overrun flag set without stored flag");

      chk_value_hold: assert property (
         !(clk_en && res_hit[gi])
         |=> $stable(slot_word[gi][ARS_VAL_MSB:ARS_VAL_LSB]))
         else $error("slot value changed without a result");

      chk_flags_keep: assert property (
         !rd_clr[gi] |=> !$fell(sto_flag[gi]) && !$fell(ovr_flag[gi]))
         else $error("slot flag cleared without a read");
   end

endmodule

// *** tb/ars_seq_model.sv ***
// behavioural conversion sequencer that delivers finished results
`timescale 1ns/1ps
module ars_seq_model (
   input wire logic sys_clk,
   output logic res_wr,
   output logic [1:0] res_slot,
   output logic [11:0] res_value
);
   initial begin
      res_wr = 1'b0;
      res_slot = 2'h0;
      res_value = 12'h000;
   end
   // gap plus one idle cycles, then one pulse; lines scrambled once released
   task automatic push(input logic [1:0] s, input logic [11:0] v,
                       input int gap);
      repeat (gap) @(posedge sys_clk);
      @(posedge sys_clk);
      res_wr <= 1'b1;
      res_slot <= s;
      res_value <= v;
      @(posedge sys_clk);
      res_wr <= 1'b0;
      res_slot <= ~s;
      res_value <= ~v;
   endtask
endmodule

// *** tb/tb_adc_result_slots_two_to_five.sv ***
// self-checking bench for the conversion result slot register bank
`timescale 1ns/1ps
module tb_adc_result_slots_two_to_five;
   import ars_pkg::*;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   ars_addr_t paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready;
   logic pslverr;
   logic irq;
   logic res_wr;
   logic [31:0] prdata;
   logic [1:0] res_slot;
   logic [11:0] res_value;
   logic [11:0] vals [4] = '{12'hfff, 12'h001, 12'ha5c, 12'h800};
   int n_fail = 0;
   int n_compared = 0;

   always #2 sys_clk = ~sys_clk;

   ars_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .res_wr(res_wr), .res_slot(res_slot),
      .res_value(res_value), .irq(irq));
   ars_seq_model u_seq (.sys_clk(sys_clk), .res_wr(res_wr),
      .res_slot(res_slot), .res_value(res_value));

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [31:0] word(logic [11:0] v, logic o, logic s);
      return {16'h0000, v, 2'b00, o, s};
   endfunction

   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input ars_addr_t a,
                      input logic [31:0] d, input logic [31:0] exp,
                      input logic err);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk(32'h0, 32'h1, "pready timeout");
         stop_test();
      end
      if (!w)
         chk(prdata, exp, "read data");
      chk({31'h0, pslverr}, {31'h0, err}, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk_irq(input logic exp);
      @(posedge sys_clk);
      #1;
      chk({31'h0, irq}, {31'h0, exp}, "irq level");
   endtask

   task automatic t_reset();
      for (int i = 0; i < 4; i++)
         apb(1'b0, ARS_OFF_SLOT2 + 8'(4 * i), 0, 0, 1'b0); // zero
      apb(1'b0, ARS_OFF_INT_STATUS, 0, 0, 1'b0);
      apb(1'b0, ARS_OFF_INT_MASK, 0, 0, 1'b0);
      $display("test reset values done");
   endtask

   task automatic t_store();
      for (int i = 0; i < 4; i++)
         u_seq.push(2'(i), vals[i], i);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, ARS_OFF_SLOT2 + 8'(4 * i), 0, word(vals[i], 0, 1),
             1'b0); // value and flag
         apb(1'b0, ARS_OFF_SLOT2 + 8'(4 * i), 0, word(vals[i], 0, 0),
             1'b0); // flag cleared
      end
      $display("test store and clear done");
   endtask

   task automatic t_ovr();
      u_seq.push(2'h1, 12'h0f0, 0);
      u_seq.push(2'h1, 12'h70e, 3);
      vals[1] = 12'h70e;
      apb(1'b0, ARS_OFF_SLOT3, 0, word(12'h70e, 1, 1), 1'b0);
      apb(1'b0, ARS_OFF_SLOT3, 0, word(12'h70e, 0, 0), 1'b0);
      apb(1'b0, ARS_OFF_SLOT2, 0, word(vals[0], 0, 0), 1'b0);
      $display("test overrun done");
   endtask

   task automatic t_write();
      apb(1'b1, ARS_OFF_SLOT4, 32'hffff_ffff, 0, 1'b0); // ignored
      apb(1'b0, ARS_OFF_SLOT4, 0, word(vals[2], 0, 0), 1'b0);
      apb(1'b0, 8'h20, 0, 0, 1'b1);
      apb(1'b1, 8'h20, 32'h1, 0, 1'b1);
      $display("test writes and unmapped done");
   endtask

   task automatic t_irq();
      apb(1'b1, ARS_OFF_INT_STATUS, 32'hff, 0, 1'b0);
      apb(1'b1, ARS_OFF_INT_MASK, 32'h10, 0, 1'b0);
      u_seq.push(2'h0, 12'h111, 0);
      chk_irq(1'b0);
      u_seq.push(2'h0, 12'h222, 2);
      chk_irq(1'b1); // overrun event
      apb(1'b0, ARS_OFF_INT_STATUS, 0, 32'h11, 1'b0);
      apb(1'b1, ARS_OFF_INT_MASK, 32'h0, 0, 1'b0);
      chk_irq(1'b0);
      apb(1'b1, ARS_OFF_INT_MASK, 32'h10, 0, 1'b0);
      chk_irq(1'b1);
      apb(1'b1, ARS_OFF_INT_STATUS, 32'h11, 0, 1'b0);
      chk_irq(1'b0);
      apb(1'b0, ARS_OFF_INT_STATUS, 0, 0, 1'b0);
      apb(1'b0, ARS_OFF_SLOT2, 0, word(12'h222, 1, 1), 1'b0);
      $display("test interrupt done");
   endtask

   task automatic t_freeze();
      fork
         apb(1'b0, ARS_OFF_SLOT4, 0, word(vals[2], 0, 0), 1'b0);
         begin
            repeat (2) @(posedge sys_clk);
            clk_en <= 1'b0;
            u_seq.push(2'h2, 12'h123, 0);
            chk({31'h0, pready}, 32'h0, "pready while frozen");
            clk_en <= 1'b1;
         end
      join
      apb(1'b0, ARS_OFF_SLOT4, 0, word(vals[2], 0, 0), 1'b0);
      $display("test clock enable done");
   endtask

   task automatic t_rerst();
      u_seq.push(2'h3, 12'h3c3, 0);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(1'b0, ARS_OFF_SLOT5, 0, 0, 1'b0); // cleared by reset
      apb(1'b0, ARS_OFF_INT_STATUS, 0, 0, 1'b0);
      apb(1'b0, ARS_OFF_INT_MASK, 0, 0, 1'b0);
      $display("test mid-run reset done");
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_store();
      t_ovr();
      t_write();
      t_irq();
      t_freeze();
      t_rerst();
      stop_test();
   end
endmodule
